// File: design/dio_consts.svh
// Register offsets, field positions and reset values for the digital I/O block
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH
`define DIO_OFF_PORT_B 3'h1
`define DIO_OFF_PORT_C 3'h2
`define DIO_OFF_IRQ_EN 3'h5
`define DIO_OFF_MODE 3'h6
`define DIO_OFF_STATUS 3'h7
`define DIO_LATCH_RST 8'hFF
`define DIO_ZERO_RST 8'h00
`define DIO_MODE_RST 7'h00
`define DIO_SYNC_RST 8'hFF
`define DIO_MODE_LOW_LSB 0
`define DIO_MODE_HIGH_LSB 2
`define DIO_MODE_EXT_LSB 4
`define DIO_MODE_EXT_EN_BIT 6
`define DIO_MODE_EXT_PEND_BIT 7
`endif

// File: design/dio_irq_line.sv
// One interrupt source: synchroniser, detector and sticky pending flag
`timescale 1ns/10ps
module dio_irq_line
    import dio_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic pin_i,
    input wire logic active_i,
    input wire logic [1:0] mode_i,
    input wire logic ack_i,
    output logic sync_o,
    output logic pend_o
);
    logic meta_q;
    logic sync_q;
    logic prev_q;
    logic pend_q;
    logic cond;
    logic fall;
    logic rise;
    dio_mode_e mode;

    // Two stages before any detector looks at the pin
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 1'b1;
            sync_q <= 1'b1;
            prev_q <= 1'b1;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    // Edge from consecutive synchronised samples
    assign mode = dio_mode_e'(mode_i);
    assign fall = prev_q & ~sync_q;
    assign rise = ~prev_q & sync_q;
    assign cond = active_i & ((mode == DIO_LEVEL_LOW) ? ~sync_q :
                  (mode == DIO_LEVEL_HIGH) ? sync_q :
                  (mode == DIO_EDGE_FALL) ? fall : rise);

    // Condition present wins over acknowledge, so a held level re-raises
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pend_q <= 1'b0;
        end else if (cond) begin
            pend_q <= 1'b1;
        end else if (ack_i) begin
            pend_q <= 1'b0;
        end
    end

    assign sync_o = sync_q;
    assign pend_o = pend_q;
endmodule

// File: design/dio_pkg.sv
// Types shared by the digital I/O block
package dio_pkg;
    // Two-bit detection mode encoding
    typedef enum logic [1:0] {
        DIO_LEVEL_LOW = 2'h0,
        DIO_LEVEL_HIGH = 2'h1,
        DIO_EDGE_FALL = 2'h2,
        DIO_EDGE_RISE = 2'h3
    } dio_mode_e;

    // Host byte access in I/O space
    typedef struct packed {
        logic wr;
        logic rd;
        logic [2:0] addr;
        logic [7:0] wdata;
    } dio_req_s;
endpackage

// File: design/dio_ports.sv
// Digital I/O ports B and C with pin interrupt and external interrupt logic
`timescale 1ns/10ps
`include "dio_consts.svh"
module dio_ports
    import dio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dio_req_s req_i,
    output logic [7:0] rdata_o,
    input wire logic [WIDTH-1:0] port_b_pin_i,
    input wire logic [WIDTH-1:0] port_c_pin_i,
    output logic [WIDTH-1:0] port_b_oe_o,
    output logic [WIDTH-1:0] port_c_oe_o,
    input wire logic ext_irq_pin_i,
    output logic irq_o
);
    // Byte-wide registers; nibble grouping of modes assumes eight lines
    if (WIDTH != 8) begin : g_width_check
        $error("dio_ports supports only WIDTH of 8");
    end

    logic [7:0] port_b_latch_q;
    logic [7:0] port_c_latch_q;
    logic [7:0] pin_irq_enable_q;
    logic [6:0] irq_mode_control_q;
    logic [7:0] rdata_q;
    logic irq_q;
    logic [7:0] b_meta_q;
    logic [7:0] b_sync_q;
    logic [7:0] c_sync;
    logic [7:0] pin_irq_pending_bits;
    logic external_irq_pending;
    logic [7:0] pin_irq_clear_bits;
    logic external_irq_clear;
    logic [1:0] low_group_irq_mode;
    logic [1:0] high_group_irq_mode;
    logic [1:0] external_irq_mode;
    logic external_irq_enable;
    logic sel_b;
    logic sel_c;
    logic sel_en;
    logic sel_mode;
    logic sel_stat;
    logic [7:0] rd_b;
    logic [7:0] rd_c;
    logic wr_b;
    logic wr_c;
    logic wr_en;
    logic wr_mode;
    logic wr_stat;
    logic [7:0] rdata_d;
    logic [7:0] mode_read;

    // Address decode shared by write strobes and read select
    assign sel_b = (req_i.addr == `DIO_OFF_PORT_B);
    assign sel_c = (req_i.addr == `DIO_OFF_PORT_C);
    assign sel_en = (req_i.addr == `DIO_OFF_IRQ_EN);
    assign sel_mode = (req_i.addr == `DIO_OFF_MODE);
    assign sel_stat = (req_i.addr == `DIO_OFF_STATUS);

    // Host byte write strobes; unmapped offsets fall through unused
    assign wr_b = req_i.wr & sel_b;
    assign wr_c = req_i.wr & sel_c;
    assign wr_en = req_i.wr & sel_en;
    assign wr_mode = req_i.wr & sel_mode;
    assign wr_stat = req_i.wr & sel_stat;

    // Acknowledge strobes; status itself is never written directly
    assign pin_irq_clear_bits =
        wr_stat ? req_i.wdata : 8'h00;
    assign external_irq_clear = wr_mode
        & req_i.wdata[`DIO_MODE_EXT_PEND_BIT];

    // Mode fields split out of the control byte
    assign low_group_irq_mode =
        irq_mode_control_q[`DIO_MODE_LOW_LSB +: 2];
    assign high_group_irq_mode = irq_mode_control_q[`DIO_MODE_HIGH_LSB +: 2];
    assign external_irq_mode =
        irq_mode_control_q[`DIO_MODE_EXT_LSB +: 2];
    assign external_irq_enable =
        irq_mode_control_q[`DIO_MODE_EXT_EN_BIT];

    // Port B latch; reset to all ones so every driver is off
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_b_latch_q <= `DIO_LATCH_RST;
        end else if (wr_b) begin
            port_b_latch_q <= req_i.wdata;
        end
    end

    // Port C latch; also gates the line interrupts
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_c_latch_q <= `DIO_LATCH_RST;
        end else if (wr_c) begin
            port_c_latch_q <= req_i.wdata;
        end
    end

    // Line enables start cleared so no source fires after reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pin_irq_enable_q <= `DIO_ZERO_RST;
        end else if (wr_en) begin
            pin_irq_enable_q <= req_i.wdata;
        end
    end

    // Mode byte; bit 7 is an acknowledge strobe, not stored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_mode_control_q <= `DIO_MODE_RST;
        end else if (wr_mode) begin
            irq_mode_control_q <= req_i.wdata[6:0];
        end
    end

    // Port B pins pass two flops before the read path sees them
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            b_meta_q <= `DIO_SYNC_RST;
            b_sync_q <= `DIO_SYNC_RST;
        end else begin
            b_meta_q <= port_b_pin_i;
            b_sync_q <= b_meta_q;
        end
    end

    // One detector per port C line; nibble picks the mode group
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_line
            dio_irq_line u_line (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .pin_i(port_c_pin_i[gi]),
                .active_i(pin_irq_enable_q[gi]
                    & port_c_latch_q[gi]),
                .mode_i((gi >= 4) ? high_group_irq_mode
                    : low_group_irq_mode),
                .ack_i(pin_irq_clear_bits[gi]),
                .sync_o(c_sync[gi]),
                .pend_o(pin_irq_pending_bits[gi])
            );
        end
    endgenerate

    // External source has its own instance of the same detector
    dio_irq_line u_ext (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ext_irq_pin_i),
        .active_i(external_irq_enable),
        .mode_i(external_irq_mode),
        .ack_i(external_irq_clear),
        .sync_o(),
        .pend_o(external_irq_pending)
    );

    // Mode readback with live external pending in bit 7
    assign mode_read = {external_irq_pending, irq_mode_control_q};

    // Masked channels read zero, enabled lines still read as data
    assign rd_b = b_sync_q & port_b_latch_q;
    assign rd_c = c_sync & port_c_latch_q;

    // Read select; unmapped offsets read zero
    assign rdata_d = sel_b ? rd_b :
        sel_c ? rd_c :
        sel_en ? pin_irq_enable_q :
        sel_mode ? mode_read :
        sel_stat ? pin_irq_pending_bits :
        8'h00;

    // Read data holds until the next read strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= `DIO_ZERO_RST;
        end else if (req_i.rd) begin
            rdata_q <= rdata_d;
        end
    end

    // Request registered, so it trails the status by one cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (|pin_irq_pending_bits)
                | external_irq_pending;
        end
    end

    // Open-collector: enable the low driver where a zero is latched
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            port_b_oe_o <= 8'h00;
            port_c_oe_o <= 8'h00;
        end else begin
            port_b_oe_o <= ~port_b_latch_q;
            port_c_oe_o <= ~port_c_latch_q;
        end
    end

    assign rdata_o = rdata_q;
    assign irq_o = irq_q;
endmodule

// File: testbench/dio_pin_model.sv
// Open-collector lines with pull-ups outside the ports block
`timescale 1ns/10ps
module dio_pin_model (
    input wire logic [7:0] drv_i,
    input wire logic [7:0] oe_i,
    output logic [7:0] pin_o
);
    // Wired-AND: either side sinking wins over the pull-up
    assign pin_o = drv_i & ~oe_i;
endmodule

// File: testbench/dio_ports_asserts.sv
// Concurrent checks on the ports block pins and host access
`timescale 1ns/10ps
module dio_ports_asserts
    import dio_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire dio_req_s req_i,
    input wire logic [7:0] rdata_o,
    input wire logic [WIDTH-1:0] port_b_pin_i,
    input wire logic [WIDTH-1:0] port_c_pin_i,
    input wire logic [WIDTH-1:0] port_b_oe_o,
    input wire logic [WIDTH-1:0] port_c_oe_o,
    input wire logic ext_irq_pin_i,
    input wire logic irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Host writes by target; irq writes may drop pending state
    wire wr_b = req_i.wr && req_i.addr == 3'h1;
    wire wr_c = req_i.wr && req_i.addr == 3'h2;
    wire wr_irq = req_i.wr && req_i.addr >= 3'h5;
    a_rst_oe: assert property (
        $fell(rst_i) |-> port_b_oe_o == '0 && port_c_oe_o == '0)
        else $error("driver on after reset");
    a_b_write: assert property (
        wr_b |-> ##2 port_b_oe_o == ~$past(req_i.wdata, 2))
        else $error("port B drivers do not follow write");
    a_c_write: assert property (
        wr_c |-> ##2 port_c_oe_o == ~$past(req_i.wdata, 2))
        else $error("port C drivers do not follow write");
    a_b_cause: assert property (
        $changed(port_b_oe_o) |-> $past(wr_b, 2))
        else $error("port B drivers moved without write");
    a_c_cause: assert property (
        $changed(port_c_oe_o) |-> $past(wr_c, 2))
        else $error("port C drivers moved without write");
    // Latch must be settled, so no write in the two cycles before
    a_mask_read: assert property (
        req_i.rd && req_i.addr == 3'h1 && !$past(req_i.wr) &&
        !$past(req_i.wr, 2) |=> (rdata_o & $past(port_b_oe_o)) == '0)
        else $error("masked channel read as one");
    a_rdata_hold: assert property (
        !req_i.rd |=> $stable(rdata_o))
        else $error("read data changed without read");
    a_irq_drop: assert property (
        $fell(irq_o) |-> $past(wr_irq, 2) || $past(wr_irq, 3))
        else $error("request dropped without acknowledge");
    c_irq_rise: cover property ($rose(irq_o));
    c_irq_fall: cover property ($fell(irq_o));
    c_port_c: cover property (wr_c);
endmodule
bind dio_ports dio_ports_asserts #(.WIDTH(WIDTH)) chk_u (.clk_i(clk_i),
    .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
    .port_b_pin_i(port_b_pin_i), .port_c_pin_i(port_c_pin_i),
    .port_b_oe_o(port_b_oe_o), .port_c_oe_o(port_c_oe_o),
    .ext_irq_pin_i(ext_irq_pin_i), .irq_o(irq_o));

// File: testbench/dio_ports_tb.sv
// Testbench for the digital I/O ports block
`timescale 1ns/10ps
module dio_ports_tb;
    import dio_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    dio_req_s req = '0;
    logic [7:0] drv_b = 8'hFF;
    logic [7:0] drv_c = 8'hA5;
    logic ext = 1'b0;
    logic [7:0] rdata, oe_b, oe_c, pin_b, pin_c, idl, md;
    logic [1:0] mm;
    logic irq;
    int n_errors = 0;
    int n_tests = 0;
    int cyc = 0;
    always #2 clk_i = ~clk_i;
    dio_pin_model pb_u (.drv_i(drv_b), .oe_i(oe_b), .pin_o(pin_b));
    dio_pin_model pc_u (.drv_i(drv_c), .oe_i(oe_c), .pin_o(pin_c));
    dio_ports dut_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(req),
        .rdata_o(rdata), .port_b_pin_i(pin_b), .port_c_pin_i(pin_c),
        .port_b_oe_o(oe_b), .port_c_oe_o(oe_c), .ext_irq_pin_i(ext),
        .irq_o(irq));
    task automatic give_verdict;
        $display("errors %0d tests %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    // One-cycle strobes, as the host interface takes them
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_i);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk_i);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk_i);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk_i);
        req.rd <= 1'b0;
        @(posedge clk_i);
        #1 chk($sformatf("reg %0d", a), e, rdata);
    endtask
    // Hang guard, several times the few hundred cycles needed
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        chk("oe b", 8'h00, oe_b);
        rd(3'h2, 8'hA5);
        rd(3'h5, 8'h00);
        rd(3'h3, 8'h00);
        wr(3'h1, 8'h5F);
        drv_b <= 8'hF0;
        repeat (4) @(posedge clk_i);
        chk("oe b", 8'hA0, oe_b);
        rd(3'h1, 8'h50);
        wr(3'h2, 8'hFF);
        // Every mode: line 0, line 7 opposite sense, external pin
        for (int m = 0; m < 4; m++) begin
            mm = m[1:0];
            idl = (m == 0 || m == 2) ? 8'h01 : 8'h80;
            md = {2'b01, mm, mm ^ 2'b01, mm};
            @(posedge clk_i);
            drv_c <= idl;
            ext <= idl[0];
            wr(3'h5, 8'h00);
            wr(3'h6, md);
            repeat (6) @(posedge clk_i);
            wr(3'h7, 8'hFF);
            wr(3'h6, md | 8'h80);
            wr(3'h5, 8'h81);
            repeat (6) @(posedge clk_i);
            rd(3'h7, 8'h00);
            rd(3'h6, md);
            @(posedge clk_i);
            drv_c <= ~idl;
            ext <= ~idl[0];
            repeat (6) @(posedge clk_i);
            // A zero write to the acknowledge offset clears nothing
            wr(3'h7, 8'h00);
            rd(3'h7, 8'h81);
            rd(3'h6, md | 8'h80);
            rd(3'h2, ~idl);
            chk("irq", 8'h01, {7'h0, irq});
            wr(3'h7, 8'h81);
            wr(3'h6, md | 8'h80);
            repeat (4) @(posedge clk_i);
            rd(3'h7, mm[1] ? 8'h00 : 8'h81);
            @(posedge clk_i);
            drv_c <= idl;
            ext <= idl[0];
            repeat (6) @(posedge clk_i);
            wr(3'h7, 8'h81);
            wr(3'h6, md | 8'h80);
            repeat (4) @(posedge clk_i);
            rd(3'h7, 8'h00);
            rd(3'h6, md);
            chk("irq", 8'h00, {7'h0, irq});
        end
        wr(3'h5, 8'h00);
        wr(3'h6, 8'h05);
        drv_c <= 8'hFF;
        ext <= 1'b1;
        repeat (6) @(posedge clk_i);
        rd(3'h7, 8'h00);
        chk("irq", 8'h00, {7'h0, irq});
        // Enabled line whose own driver pulls it low must stay quiet
        wr(3'h6, 8'h00);
        wr(3'h2, 8'hFE);
        wr(3'h5, 8'h01);
        repeat (6) @(posedge clk_i);
        rd(3'h7, 8'h00);
        rd(3'h2, 8'hFE);
        chk("irq", 8'h00, {7'h0, irq});
        // Second reset in mid-run restores latches, enables and modes
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rd(3'h1, 8'hF0);
        rd(3'h2, 8'hFF);
        rd(3'h6, 8'h00);
        rd(3'h5, 8'h00);
        chk("oe c", 8'h00, oe_c);
        give_verdict();
    end
endmodule
